/* hdl/csd_card.sv */
/*
 * Card end: the 128-bit card-specific data register with its fixed
 * fields, the programmable byte, the checksum and the command gate.
 * Assumes the host holds a link request until it sees ack, and that
 * user-side command requests are synchronous one-cycle pulses.
 */
// Overview of operation
// - Class mask fixed at 0x0F5.
// - Block length is two to the exponent.
// - Partial-read flag gates short read blocks.
// - Write misalignment flag reads fixed zero.
// - Read misalignment flag reads fixed zero.
// - Driver stage flag reads zero, none present.
// - Host computes capacity from size fields.
// - Each model reports its size pair.
// - Low-voltage current codes map to tenths of milliamperes.
// - High-voltage current codes map to tenths of milliamperes.
// - Erase unit is size plus one times multiplier plus one.
// - Protect group size field reads eight.
// - Group protection enable reads one.
// - Recommended error code field reads zero.
// - Program time factor reads four.
// - Write length coded alike, no partial writes.
// - Copy flag programmable once, one is copy.
// - Permanent protection blocks writes and erases until reset.
// - Temporary protection blocks writes and erases.
// - File format codes meaningful only in group zero.
// - Error code type: none or BCH.
// - Checksum covers the register contents.
// - Only programmable fields may change.
`timescale 1ns/10ps
module csd_card #(
    parameter logic [11:0] DEV_SIZE    = 12'h7A7,
    parameter logic [2:0]  SIZE_MULT   = 3'h3,
    parameter logic [4:0]  ERASE_SIZE  = 5'h00,
    parameter logic [2:0]  RD_CUR_LO   = 3'h2,
    parameter logic [2:0]  RD_CUR_HI   = 3'h2,
    parameter logic [2:0]  WR_CUR_LO   = 3'h4,
    parameter logic [2:0]  WR_CUR_HI   = 3'h4,
    parameter logic        RD_PARTIAL  = 1'b0,
    parameter logic [3:0]  RD_EXP      = csd_pkg::BLK_EXP,
    parameter logic [3:0]  WR_EXP      = csd_pkg::BLK_EXP
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_B_I,
    csd_link_if.card         link,
    input  wire logic        CMD_VALID_I,
    input  wire logic [1:0]  CMD_KIND_I,
    input  wire logic [11:0] CMD_LEN_I,
    output logic             CMD_OK_O,
    output logic             CMD_REJECT_O,
    output logic             PERM_PROTECT_O,
    output logic             TMP_PROTECT_O
);

    // Exponents of 12 and above are reserved, so such a card cannot exist.
    // The check stops elaboration, because a reserved exponent would make
    // the length decode below serve a block size that no host can use.
    if (RD_EXP >= csd_pkg::EXP_RSVD || WR_EXP >= csd_pkg::EXP_RSVD) begin
        $error("block length exponent out of range");
    end

    // Everything above the programmable byte is a constant of the model.
    localparam logic [111:0] FIXED_HI = {
        csd_pkg::STRUCT_VAL,
        csd_pkg::SPEC_VAL,
        2'h0,
        csd_pkg::TAAC_VAL,
        csd_pkg::NSAC_VAL,
        csd_pkg::SPEED_VAL,
        csd_pkg::CLASS_VAL,
        RD_EXP,
        RD_PARTIAL,
        1'b0,
        1'b0,
        1'b0,
        2'h0,
        DEV_SIZE,
        RD_CUR_LO,
        RD_CUR_HI,
        WR_CUR_LO,
        WR_CUR_HI,
        SIZE_MULT,
        ERASE_SIZE,
        csd_pkg::EGM_VAL,
        csd_pkg::WPGS_VAL,
        csd_pkg::WPGE_VAL,
        csd_pkg::ECCDEF_VAL,
        csd_pkg::R2W_VAL,
        WR_EXP,
        1'b0,
        5'h00
    };
    localparam logic [6:0] CRC_RST = csd_pkg::crc7({FIXED_HI,
                                                    csd_pkg::PROG_RST});

    logic [7:0]   prog_reg;
    logic [6:0]   crc_reg;
    logic         ack_reg;
    logic [31:0]  rdata_reg;
    logic         refused_reg;
    logic         cmd_ok_reg;
    logic         cmd_reject_reg;

    wire  [127:0] csd_word;
    wire  [31:0]  word_sel;
    wire          link_take;
    wire  [7:0]   prog_next;
    wire          otp_clear;
    wire          perm_now;
    wire          tmp_now;
    wire  [11:0]  rd_len;
    wire  [11:0]  wr_len;
    wire          is_read;
    wire          read_bad;
    wire          write_bad;
    wire          cmd_bad;

    // Bit 0 is the frame stop position and always reads one.
    assign csd_word  = {FIXED_HI, prog_reg, crc_reg, 1'b1};
    assign word_sel  = csd_word[link.idx * csd_pkg::WORD_W +: csd_pkg::WORD_W];
    assign link_take = link.req && !ack_reg;

    // One-time bits can only be set; all other programmable bits follow
    // the written byte.
    assign prog_next = {
        link.wbyte[csd_pkg::FFG_POS],
        prog_reg[csd_pkg::COPY_POS] | link.wbyte[csd_pkg::COPY_POS],
        prog_reg[csd_pkg::PERM_POS] | link.wbyte[csd_pkg::PERM_POS],
        link.wbyte[csd_pkg::TMP_POS],
        link.wbyte[csd_pkg::FF_LSB +: 2],
        link.wbyte[csd_pkg::ECC_LSB +: 2]
    };
    // An attempt to clear a one-time bit is reported but has no effect.
    assign otp_clear =
        (prog_reg[csd_pkg::COPY_POS] && !link.wbyte[csd_pkg::COPY_POS]) ||
        (prog_reg[csd_pkg::PERM_POS] && !link.wbyte[csd_pkg::PERM_POS]);

    assign perm_now  = prog_reg[csd_pkg::PERM_POS];
    assign tmp_now   = prog_reg[csd_pkg::TMP_POS];
    assign rd_len    = 12'h001 << RD_EXP;
    assign wr_len    = 12'h001 << WR_EXP;
    assign is_read   = (CMD_KIND_I == csd_pkg::CMD_READ);

    // A zero length is never a valid block on the read or write path; erase ignores the length.
    assign read_bad  = (CMD_LEN_I == 12'h000) || (CMD_LEN_I > rd_len) ||
                       (!RD_PARTIAL && (CMD_LEN_I != rd_len));
    assign write_bad = perm_now ||
                       tmp_now ||
                       ((CMD_KIND_I == csd_pkg::CMD_WRITE) &&
                        (CMD_LEN_I != wr_len));
    assign cmd_bad   = is_read ? read_bad :
                       (CMD_KIND_I == csd_pkg::CMD_ERASE ||
                        CMD_KIND_I == csd_pkg::CMD_WRITE) ? write_bad :
                       1'b1;

    // The link answers one cycle after the request and then drops ack for
    // a cycle, so a held request is served again every second cycle.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ack_reg     <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            refused_reg <= 1'b0;
        end else begin
            ack_reg <= link_take;
            if (link_take) begin
                rdata_reg   <= word_sel;
                refused_reg <= link.prog && otp_clear;
            end
        end
    end

    // Only the programmable byte and its checksum are storage.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            prog_reg <= csd_pkg::PROG_RST;
            crc_reg  <= CRC_RST;
        end else if (link_take && link.prog) begin
            prog_reg <= prog_next;
            crc_reg  <= csd_pkg::crc7({FIXED_HI, prog_next});
        end
    end

    // Protection is judged before length, so a protected card refuses
    // every write and erase whatever length it is given.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cmd_ok_reg     <= 1'b0;
            cmd_reject_reg <= 1'b0;
        end else begin
            cmd_ok_reg     <= CMD_VALID_I && !cmd_bad;
            cmd_reject_reg <= CMD_VALID_I && cmd_bad;
        end
    end

    assign link.ack       = ack_reg;
    assign link.rdata     = rdata_reg;
    assign link.refused   = refused_reg;
    assign CMD_OK_O       = cmd_ok_reg;
    assign CMD_REJECT_O   = cmd_reject_reg;
    assign PERM_PROTECT_O = prog_reg[csd_pkg::PERM_POS];
    assign TMP_PROTECT_O  = prog_reg[csd_pkg::TMP_POS];

endmodule

/* hdl/csd_host.sv */
/*
 * Host end: an Avalon-MM slave with waitrequest that fetches the card's
 * 128-bit register into a shadow, decodes it, and programs the byte.
 * Assumes the card answers each held link request with a one-cycle ack.
 */
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
module csd_host (
    input  wire logic        MCLK_I,
    input  wire logic        RST_B_I,
    csd_link_if.host         link,
    input  wire logic [5:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic [31:0]      AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O
);

    typedef enum logic [1:0] {
        HST_IDLE,
        HST_FETCH,
        HST_PROG
    } csd_hst_t;

    csd_hst_t    state_reg;
    logic [31:0] shadow_reg [0:3];
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  wdata_reg;
    logic        valid_reg;
    logic        refused_reg;
    logic        req_reg;
    logic        prog_reg;
    logic [1:0]  idx_reg;
    logic [7:0]  wbyte_reg;

    wire [127:0] shadow_all;
    wire [11:0]  c_size;
    wire [2:0]   c_mult;
    wire [3:0]   rd_exp;
    wire [4:0]   eg_size;
    wire [4:0]   eg_mult;
    wire [7:0]   pbyte;
    wire         exp_rsvd;
    wire         ff_rsvd;
    wire         ecc_undef;
    wire [21:0]  block_count;
    wire [31:0]  block_len;
    wire [11:0]  erase_units;
    wire [31:0]  curr_word;
    wire [31:0]  stat_word;
    wire [31:0]  rd_mux;
    wire         commit;
    wire         go_fetch;
    wire         go_prog;
    wire         busy;

    assign shadow_all = {shadow_reg[3], shadow_reg[2],
                         shadow_reg[1], shadow_reg[0]};
    assign c_size  = shadow_all[csd_pkg::CSIZE_LSB +: 12];
    assign c_mult  = shadow_all[csd_pkg::MULT_LSB +: 3];
    assign rd_exp  = shadow_all[csd_pkg::RD_EXP_LSB +: 4];
    assign eg_size = shadow_all[csd_pkg::EGS_LSB +: 5];
    assign eg_mult = shadow_all[csd_pkg::EGM_LSB +: 5];
    assign pbyte   = shadow_all[csd_pkg::PROG_LSB +: 8];

    assign exp_rsvd  = (rd_exp >= csd_pkg::EXP_RSVD);
    assign ff_rsvd   = pbyte[csd_pkg::FFG_POS];
    assign ecc_undef = (pbyte[csd_pkg::ECC_LSB +: 2] >
                        csd_pkg::ECC_BCH);
    assign block_count = ({10'h000, c_size} + 22'h000001)
                         << ({1'b0, c_mult} + 4'h2);
    assign block_len   = exp_rsvd ? 32'h0000_0000
                                  : (32'h0000_0001 << rd_exp);
    assign erase_units = ({7'h00, eg_size} + 12'h001) *
                         ({7'h00, eg_mult} + 12'h001);
    assign curr_word = {
        csd_pkg::CUR_HI[shadow_all[csd_pkg::RCHI_LSB +: 3]],
        csd_pkg::CUR_LO[shadow_all[csd_pkg::RCLO_LSB +: 3]]
    };

    assign busy = (state_reg != HST_IDLE);
    assign stat_word = {24'h000000, refused_reg, valid_reg,
                        pbyte[csd_pkg::TMP_POS], pbyte[csd_pkg::PERM_POS],
                        ecc_undef, ff_rsvd, exp_rsvd, busy};

    assign rd_mux =
        (AVS_ADDRESS_I == csd_pkg::OFS_CTRL)   ? {31'h0, busy} :
        (AVS_ADDRESS_I == csd_pkg::OFS_STAT)   ? stat_word :
        (AVS_ADDRESS_I == csd_pkg::OFS_WDATA)  ? {24'h0, wdata_reg} :
        (AVS_ADDRESS_I == csd_pkg::OFS_BLKCNT) ? {10'h0, block_count} :
        (AVS_ADDRESS_I == csd_pkg::OFS_BLKLEN) ? block_len :
        (AVS_ADDRESS_I == csd_pkg::OFS_ERASE)  ? {20'h0, erase_units} :
        (AVS_ADDRESS_I == csd_pkg::OFS_CURR)   ? curr_word :
        (AVS_ADDRESS_I[5:4] == csd_pkg::OFS_SHADOW[5:4] &&
         AVS_ADDRESS_I[1:0] == 2'h0) ? shadow_reg[AVS_ADDRESS_I[3:2]] :
        32'h0000_0000;

    // A write takes effect at the edge where waitrequest is seen low.
    assign commit   = AVS_WRITE_I && !wait_reg && AVS_BYTEENABLE_I[0];
    assign go_fetch = commit && (AVS_ADDRESS_I == csd_pkg::OFS_CTRL) &&
                      AVS_WRITEDATA_I[csd_pkg::CTRL_FETCH];
    assign go_prog  = commit && (AVS_ADDRESS_I == csd_pkg::OFS_CTRL) &&
                      AVS_WRITEDATA_I[csd_pkg::CTRL_PROG] &&
                      !AVS_WRITEDATA_I[csd_pkg::CTRL_FETCH];

    // Every access costs exactly two cycles: waitrequest drops for one.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !((AVS_READ_I || AVS_WRITE_I) && wait_reg);
            if ((AVS_READ_I || AVS_WRITE_I) && wait_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wdata_reg <= 8'h00;
        end else if (commit && AVS_ADDRESS_I == csd_pkg::OFS_WDATA) begin
            wdata_reg <= AVS_WRITEDATA_I[7:0];
        end
    end

    // Commands that arrive while busy are dropped; software polls busy.
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_reg   <= HST_IDLE;
            req_reg     <= 1'b0;
            prog_reg    <= 1'b0;
            idx_reg     <= 2'h0;
            wbyte_reg   <= 8'h00;
            valid_reg   <= 1'b0;
            refused_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                shadow_reg[i] <= 32'h0000_0000;
            end
        end else begin
            unique case (state_reg)
                HST_IDLE: begin
                    if (go_fetch || go_prog) begin
                        state_reg <= go_fetch ? HST_FETCH : HST_PROG;
                        req_reg   <= 1'b1;
                        prog_reg  <= go_prog;
                        idx_reg   <= 2'h0;
                        wbyte_reg <= wdata_reg;
                    end
                end
                HST_FETCH: begin
                    if (link.ack) begin
                        shadow_reg[idx_reg] <= link.rdata;
                        idx_reg             <= idx_reg + 2'h1;
                        if (idx_reg == 2'h3) begin
                            req_reg   <= 1'b0;
                            valid_reg <= 1'b1;
                            state_reg <= HST_IDLE;
                        end
                    end
                end
                HST_PROG: begin
                    if (link.ack) begin
                        req_reg     <= 1'b0;
                        prog_reg    <= 1'b0;
                        refused_reg <= link.refused;
                        valid_reg   <= 1'b0;
                        state_reg   <= HST_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.req          = req_reg;
    assign link.prog         = prog_reg;
    assign link.idx          = idx_reg;
    assign link.wbyte        = wbyte_reg;
    assign AVS_READDATA_O    = rdata_reg;
    assign AVS_WAITREQUEST_O = wait_reg;

endmodule

/* hdl/csd_link_if.sv */
/*
 * Word link between the host controller and the card register bank.
 * Assumes both ends run on the same clock; request is held until ack.
 */
`timescale 1ns/10ps
interface csd_link_if;
    logic        req;
    logic        prog;
    logic [1:0]  idx;
    logic [7:0]  wbyte;
    logic        ack;
    logic [31:0] rdata;
    logic        refused;

    modport card (input req, prog, idx, wbyte,
                  output ack, rdata, refused);
    modport host (output req, prog, idx, wbyte,
                  input ack, rdata, refused);
endinterface

/* hdl/csd_pkg.sv */
/*
 * Shared constants of the card-specific data block: field positions,
 * fixed field values, reset values, host register map and the checksum.
 * Assumes nothing of its surroundings; both ends and the bench use it.
 */
package csd_pkg;

    localparam int WORD_W = 32;
    localparam int WORDS  = 4;

    // Field positions inside the 128-bit card-specific data word.
    localparam int CLASS_LSB   = 84;
    localparam int RD_EXP_LSB  = 80;
    localparam int RD_PART_BIT = 79;
    localparam int WR_MIS_BIT  = 78;
    localparam int RD_MIS_BIT  = 77;
    localparam int DSR_BIT     = 76;
    localparam int CSIZE_LSB   = 62;
    localparam int RCLO_LSB    = 59;
    localparam int RCHI_LSB    = 56;
    localparam int WCLO_LSB    = 53;
    localparam int WCHI_LSB    = 50;
    localparam int MULT_LSB    = 47;
    localparam int EGS_LSB     = 42;
    localparam int EGM_LSB     = 37;
    localparam int WPGS_LSB    = 32;
    localparam int WPGE_BIT    = 31;
    localparam int ECCDEF_LSB  = 29;
    localparam int R2W_LSB     = 26;
    localparam int WR_EXP_LSB  = 22;
    localparam int WR_PART_BIT = 21;
    localparam int PROG_LSB    = 8;
    localparam int CRC_LSB     = 1;

    // Positions inside the programmable byte, bits 15:8 of the word.
    localparam int FFG_POS  = 7;
    localparam int COPY_POS = 6;
    localparam int PERM_POS = 5;
    localparam int TMP_POS  = 4;
    localparam int FF_LSB   = 2;
    localparam int ECC_LSB  = 0;

    // Fixed field values.
    localparam logic [1:0]  STRUCT_VAL = 2'h2;
    localparam logic [3:0]  SPEC_VAL   = 4'h3;
    localparam logic [7:0]  TAAC_VAL   = 8'h26;
    localparam logic [7:0]  NSAC_VAL   = 8'h01;
    localparam logic [7:0]  SPEED_VAL  = 8'h2A;
    localparam logic [11:0] CLASS_VAL  = 12'h0F5;
    localparam logic [3:0]  BLK_EXP    = 4'h9;
    localparam logic [3:0]  EXP_RSVD   = 4'hC;
    localparam logic [4:0]  EGM_VAL    = 5'h1F;
    localparam logic [4:0]  WPGS_VAL   = 5'h08;
    localparam logic        WPGE_VAL   = 1'h1;
    localparam logic [1:0]  ECCDEF_VAL = 2'h0;
    localparam logic [2:0]  R2W_VAL    = 3'h4;
    localparam logic [7:0]  PROG_RST   = 8'h40;
    localparam logic [1:0]  ECC_BCH    = 2'h1;
    localparam logic [6:0]  CRC_POLY   = 7'h09;

    // Supply current per code, in tenths of a milliampere.
    localparam logic [15:0] CUR_LO [0:7] = '{16'h0005, 16'h000A, 16'h0032,
        16'h0064, 16'h00FA, 16'h015E, 16'h0258, 16'h03E8};
    localparam logic [15:0] CUR_HI [0:7] = '{16'h000A, 16'h0032, 16'h0064,
        16'h00FA, 16'h015E, 16'h01C2, 16'h0320, 16'h07D0};

    // Host register map, byte addresses.
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_STAT   = 6'h04;
    localparam logic [5:0] OFS_WDATA  = 6'h08;
    localparam logic [5:0] OFS_BLKCNT = 6'h0C;
    localparam logic [5:0] OFS_BLKLEN = 6'h10;
    localparam logic [5:0] OFS_ERASE  = 6'h14;
    localparam logic [5:0] OFS_CURR   = 6'h18;
    localparam logic [5:0] OFS_SHADOW = 6'h20;

    localparam int CTRL_FETCH = 0;
    localparam int CTRL_PROG  = 1;
    localparam int ST_BUSY    = 0;
    localparam int ST_EXPRSV  = 1;
    localparam int ST_FFRSV   = 2;
    localparam int ST_ECCUND  = 3;
    localparam int ST_PERM    = 4;
    localparam int ST_TMP     = 5;
    localparam int ST_VALID   = 6;
    localparam int ST_REFUSED = 7;

    typedef enum logic [1:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_ERASE
    } csd_cmd_t;

    function automatic logic [6:0] crc7(input logic [119:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_POLY;
            end
        end
        return c;
    endfunction

endpackage

/* tb/card_specific_data_fields_tb.sv */
/*
 * Bench joining host and card ends; drives the Avalon side and the
 * user command port. Assumes default card parameters.
 */
`timescale 1ns/10ps
module card_specific_data_fields_tb;
    logic        clk, rst_b, rd, wr, cv, wait_r, ok, rej, perm, tmp;
    logic [5:0]  adr;
    logic [1:0]  ck;
    logic [11:0] cl;
    logic [31:0] wd, rdat, q;
    logic [31:0] ew [4];
    logic [6:0]  crc;
    logic [119:0] body;
    int          fails, n_tests, cyc;

    csd_link_if csd_link_if_i ();
    csd_card csd_card_i (.MCLK_I(clk), .RST_B_I(rst_b),
        .link(csd_link_if_i), .CMD_VALID_I(cv), .CMD_KIND_I(ck),
        .CMD_LEN_I(cl), .CMD_OK_O(ok), .CMD_REJECT_O(rej),
        .PERM_PROTECT_O(perm), .TMP_PROTECT_O(tmp));
    csd_host csd_host_i (.MCLK_I(clk), .RST_B_I(rst_b),
        .link(csd_link_if_i), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wait_r));
    csd_link_sva csd_link_sva_i (.MCLK_I(clk), .RST_B_I(rst_b),
        .req(csd_link_if_i.req), .prog(csd_link_if_i.prog),
        .idx(csd_link_if_i.idx), .wbyte(csd_link_if_i.wbyte),
        .ack(csd_link_if_i.ack), .refused(csd_link_if_i.refused),
        .rdata(csd_link_if_i.rdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One access; the edge where waitrequest is seen low completes it.
    // Only the watchdog ends a wait that never finishes.
    task automatic av(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wait_r !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic idle();
        do begin
            av(1'b0, csd_pkg::OFS_CTRL, 32'h0);
        end while (q[0] !== 1'b0);
    endtask

    task automatic fetch();
        av(1'b1, csd_pkg::OFS_CTRL, 32'h1);
        idle();
    endtask

    task automatic prg(input logic [7:0] b);
        av(1'b1, csd_pkg::OFS_WDATA, {24'h0, b});
        av(1'b1, csd_pkg::OFS_CTRL, 32'h2);
        idle();
    endtask

    task automatic cmd(input logic [1:0] k, input logic [11:0] l,
                       input logic e);
        cv <= 1'b1;
        ck <= k;
        cl <= l;
        @(posedge clk);
        cv <= 1'b0;
        @(posedge clk);
        chk("cmd_ok", {31'h0, ok}, {31'h0, e});
        chk("cmd_reject", {31'h0, rej}, {31'h0, !e});
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    localparam logic [5:0]  DA [6] = '{6'h0C, 6'h10, 6'h14, 6'h18, 6'h04,
        6'h3C};
    localparam logic [31:0] DE [6] = '{32'hF500, 32'h200, 32'h20,
        32'h00640032, 32'h40, 32'h0};
    localparam logic [1:0]  CK [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2,
        2'h3};
    localparam logic [11:0] CL [7] = '{12'h200, 12'h100, 12'h0, 12'h200,
        12'h100, 12'h0, 12'h200};
    localparam logic        CE [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
        1'b0};

    initial begin
        {rst_b, adr, rd, wr, wd, cv, ck, cl, fails, n_tests, cyc} = '0;
        ew[0] = {1'b1, 2'h0, 3'h4, 4'h9, 1'b0, 5'h00, 8'h40, 8'h01};
        ew[1] = {2'h3, 3'h2, 3'h2, 3'h4, 3'h4, 3'h3, 5'h00, 5'h1F, 5'h08};
        ew[2] = {12'h0F5, 4'h9, 6'h00, 10'h1E9};
        ew[3] = {csd_pkg::STRUCT_VAL, csd_pkg::SPEC_VAL, 2'h0,
            csd_pkg::TAAC_VAL, csd_pkg::NSAC_VAL, csd_pkg::SPEED_VAL};
        // Checksum worked out here, bit by bit, with the generator 0x09.
        body = {ew[3], ew[2], ew[1], ew[0][31:8]};
        crc = 7'h00;
        for (int b = 119; b >= 0; b--)
            crc = {crc[5:0], 1'b0} ^ ({7{crc[6] ^ body[b]}} & 7'h09);
        ew[0][7:1] = crc;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        fetch();
        for (int i = 0; i < 4; i++) begin
            av(1'b0, csd_pkg::OFS_SHADOW + 6'(4 * i), 32'h0);
            chk("shadow", q, ew[i]);
        end
        for (int i = 0; i < 6; i++) begin
            av(1'b0, DA[i], 32'h0);
            chk("decode", q, DE[i]);
        end
        for (int i = 0; i < 7; i++)
            cmd(CK[i], CL[i], CE[i]);
        prg(8'h50);
        chk("tmp", {31'h0, tmp}, 32'h1);
        cmd(2'h1, 12'h200, 1'b0);
        cmd(2'h2, 12'h0, 1'b0);
        cmd(2'h0, 12'h200, 1'b1);
        prg(8'h40);
        cmd(2'h1, 12'h200, 1'b1);
        prg(8'h00);
        fetch();
        av(1'b0, csd_pkg::OFS_SHADOW, 32'h0);
        chk("copy", {31'h0, q[14]}, 32'h1);
        av(1'b0, csd_pkg::OFS_STAT, 32'h0);
        chk("refused", {31'h0, q[7]}, 32'h1);
        prg(8'h60);
        chk("perm", {31'h0, perm}, 32'h1);
        prg(8'hC2);
        chk("perm_kept", {31'h0, perm}, 32'h1);
        cmd(2'h1, 12'h200, 1'b0);
        cmd(2'h2, 12'h0, 1'b0);
        fetch();
        av(1'b0, csd_pkg::OFS_STAT, 32'h0);
        chk("status", q, 32'hDC);
        av(1'b0, csd_pkg::OFS_SHADOW, 32'h0);
        chk("prog_byte", {24'h0, q[15:8]}, 32'hE2);
        av(1'b0, csd_pkg::OFS_SHADOW + 6'h4, 32'h0);
        chk("fixed_word", q, ew[1]);
        complete_run();
    end
endmodule

/* tb/csd_link_sva.sv */
/*
 * Checker on the word link between host and card ends.
 * Assumes the card runs with default parameters and one shared clock.
 */
`timescale 1ns/10ps
module csd_link_sva (
    input wire logic        MCLK_I,
    input wire logic        RST_B_I,
    input wire logic        req,
    input wire logic        prog,
    input wire logic [1:0]  idx,
    input wire logic [7:0]  wbyte,
    input wire logic        ack,
    input wire logic        refused,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_B_I);

    wire logic w0 = ack && !prog && (idx == 2'h0);
    wire logic w1 = ack && !prog && (idx == 2'h1);
    wire logic w2 = ack && !prog && (idx == 2'h2);

    a_class_mask: assert property (w2 |-> rdata[31:20] == 12'h0F5)
        else $error("class mask wrong");
    a_read_exp: assert property (w2 |-> rdata[19:16] == 4'h9)
        else $error("read exponent wrong");
    a_read_partial: assert property (w2 |-> !rdata[15])
        else $error("read partial flag wrong");
    a_fixed_flags: assert property (w2 |-> rdata[14:13] == 2'h0)
        else $error("misalignment flags wrong");
    a_driver_stage: assert property (w2 |-> rdata[12:10] == 3'h0)
        else $error("driver stage or reserved bits wrong");
    a_erase_mult: assert property (w1 |-> rdata[9:5] == 5'h1F)
        else $error("erase multiplier wrong");
    a_protect_size: assert property (w1 |-> rdata[4:0] == 5'h08)
        else $error("protect group size wrong");
    a_group_enable: assert property (w0 |-> rdata[31])
        else $error("group protection enable wrong");
    a_group_fields: assert property (w0 |-> rdata[30:26] == 5'h04)
        else $error("error code or program factor wrong");
    a_write_exp: assert property (w0 |-> rdata[25:16] == 10'h240)
        else $error("write exponent wrong");
    a_ack_follows: assert property (req && !ack |=> ack)
        else $error("request not answered");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
endmodule
